//--- rtl/fcp_pwm_timer.sv
// Overview of operation
// - Four 8-bit channels drive outputs 3..0
// - Channel runs and drives only when enabled; a joined high channel runs on the low channel's enable
// - Period match restarts: polarity level, counter zero
// - Duty match inverts output rest of period
// - Polarity zero starts low, one starts high
// - Buffered period/duty load at counter clear
// - Counter write clears it; always readable
// - Clock A divides by 1,2,4,8
// - Clock B divides by two to field
// - Clock S is A over divisor, halved
// - Clock pick selects A/B or S
// - Join bits pair channels into 16 bits
// - Joined pair uses low channel clock, pin
// - High byte read latches low byte
// - Low byte write clears; high write ignored
// - Test bits default zero, special mode only
//
// Chosen here: the register addresses and the plain strobed port.
`default_nettype none
module fcp_pwm_timer
(
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       ce_i,
   input  wire logic       test_mode_i,
   input  wire logic [4:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic      [3:0] pwm_o,
   output logic      [3:0] pwm_drive_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] clk_sel_r, pol_clk_r, scale_r, enable_r;
   logic [7:0] cnt_r [4], per_r [4], dty_r [4], per_act_r [4], dty_act_r [4];
   logic [3:0] lvl_r;
   logic [7:0] rdata_r, snap_r [2];
   logic [1:0] snap_vld_r;
   logic [6:0] pre_r;
   logic [7:0] sdiv_r;
   logic       s_half_r, s_tick_r;

   // Address decode
   wire        in_cnt   = addr_i[4:2] == fcp_pkg::OFS_CNT_BASE[4:2];
   wire        in_per   = addr_i[4:2] == fcp_pkg::OFS_PER_BASE[4:2];
   wire        in_dty   = addr_i[4:2] == fcp_pkg::OFS_DTY_BASE[4:2];
   wire [1:0]  sel_ch   = addr_i[1:0];
   wire [1:0]  join_w   = {clk_sel_r[fcp_pkg::JOIN2_BIT], clk_sel_r[fcp_pkg::JOIN1_BIT]};
   wire [1:0]  pre_a    = clk_sel_r[fcp_pkg::PRE_A_LSB +: 2];
   wire [2:0]  pre_b    = clk_sel_r[fcp_pkg::PRE_B_LSB +: 3];
   wire [3:0]  pick     = pol_clk_r[fcp_pkg::PICK_LSB +: 4];
   wire [3:0]  pol      = pol_clk_r[fcp_pkg::POL_LSB +: 4];
   wire [3:0]  en       = enable_r[fcp_pkg::EN_LSB +: 4];
   wire        no_clr   = enable_r[fcp_pkg::NOCLR_BIT];
   wire        s_test   = enable_r[fcp_pkg::STEST_BIT];

   // Tick of a divide-by-2^n prescaler: all low n bits of the count set
   function automatic logic pre_tick(input logic [6:0] c, input logic [2:0] n);
      logic [6:0] m;
      m = 7'((8'h01 << n) - 8'h01);
      return (c & m) == m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Clock generation: ticks are one-cycle enables off clk_i
   wire        tick_a = pre_tick(pre_r, {1'b0, pre_a});
   wire        tick_b = pre_tick(pre_r, pre_b);
   wire [7:0]  sdiv_last = scale_r - 8'h01;                             // 0 gives 256
   wire        s_wrap = tick_a && (sdiv_r == sdiv_last);
   wire        tick_s = s_wrap && s_half_r;                             // Final halving

   // Prescaler and scaled divider
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         pre_r    <= 7'h00;
         sdiv_r   <= 8'h00;
         s_half_r <= 1'b0;
         s_tick_r <= 1'b0;
      end
      else if (ce_i)
      begin
         pre_r    <= pre_r + 7'h01;
         s_tick_r <= tick_s;
         if (wr_i && addr_i == fcp_pkg::OFS_SCALE)
            sdiv_r <= 8'h00;                                            // Restart on new divisor
         else if (s_wrap)
         begin
            sdiv_r   <= 8'h00;
            s_half_r <= ~s_half_r;
         end
         else if (tick_a)
            sdiv_r <= sdiv_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel ticks; joined pairs use the low channel's pick
   wire [3:0] raw_tick;
   assign raw_tick[0] = pick[0] ? tick_s : tick_a;
   assign raw_tick[1] = pick[1] ? tick_s : tick_a;
   assign raw_tick[2] = pick[2] ? tick_s : tick_b;
   assign raw_tick[3] = pick[3] ? tick_s : tick_b;

   // 16-bit views of each pair: high byte is the odd-numbered (first) channel
   wire [15:0] cnt16 [2], per16 [2], dty16 [2];
   wire [1:0]  per_m16, dty_m16, tick16, run16;
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_pair
         assign cnt16[p]  = {cnt_r[2*p], cnt_r[2*p+1]};
         assign per16[p]  = {per_act_r[2*p], per_act_r[2*p+1]};
         assign dty16[p]  = {dty_act_r[2*p], dty_act_r[2*p+1]};
         assign per_m16[p] = cnt16[p] == per16[p];
         assign dty_m16[p] = cnt16[p] == dty16[p];
         assign tick16[p] = raw_tick[2*p+1];
         assign run16[p]  = en[2*p+1];
      end
   endgenerate

   // Counter-clear requests from software
   wire [3:0] cnt_wr;
   genvar c;
   generate
      for (c = 0; c < 4; c++)
      begin : g_wr
         wire joined = join_w[c/2];
         wire hit    = wr_i && in_cnt && sel_ch == 2'(c);
         wire partner_hit = wr_i && in_cnt && sel_ch == 2'(c | 1);
         // Joined: low-byte write clears both, high-byte write ignored
         assign cnt_wr[c] = joined ? partner_hit : hit;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Channel engines
   generate
      for (c = 0; c < 4; c++)
      begin : g_ch
         wire joined = join_w[c/2];
         wire run    = joined ? run16[c/2] : en[c];
         wire tk     = (joined ? tick16[c/2] : raw_tick[c]) && run;
         wire pm     = joined ? per_m16[c/2] : cnt_r[c] == per_act_r[c];
         wire dm     = joined ? dty_m16[c/2] : cnt_r[c] == dty_act_r[c];
         wire wrap   = tk && pm;
         wire [7:0] inc = joined ? (c % 2 == 1 ? cnt_r[c] + 8'h01 :
                          cnt_r[c] + {7'h00, &cnt_r[c | 1]}) : cnt_r[c] + 8'h01;
         wire pol_c  = joined ? pol[c | 1] : pol[c];
         always_ff @(posedge clk_i)
         begin
            if (srst_i)
            begin
               cnt_r[c]     <= 8'h00;
               per_act_r[c] <= fcp_pkg::RST_PER;
               dty_act_r[c] <= fcp_pkg::RST_DTY;
               lvl_r[c]     <= 1'b0;
            end
            else if (ce_i)
            begin
               if (cnt_wr[c] || (wrap && !no_clr))
               begin
                  cnt_r[c]     <= 8'h00;
                  per_act_r[c] <= per_r[c];
                  dty_act_r[c] <= dty_r[c];
               end
               else if (tk)
                  cnt_r[c] <= inc;
               if (wrap || cnt_wr[c])
                  lvl_r[c] <= pol_c;
               else if (tk && dm)
                  lvl_r[c] <= ~pol_c;
            end                                                          // Disabled holds
         end
      end
   endgenerate

   // Pins: joined high-order pin is released for general use
   assign pwm_o = lvl_r;
   assign pwm_drive_o = en & ~{1'b0, join_w[1], 1'b0, join_w[0]};

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         clk_sel_r <= fcp_pkg::RST_CTRL;
         pol_clk_r <= fcp_pkg::RST_CTRL;
         scale_r   <= fcp_pkg::RST_CTRL;
         enable_r  <= fcp_pkg::RST_CTRL;
         for (int i = 0; i < 4; i++)
         begin
            per_r[i] <= fcp_pkg::RST_PER;
            dty_r[i] <= fcp_pkg::RST_DTY;
         end
      end
      else if (ce_i && wr_i)
      begin
         if (addr_i == fcp_pkg::OFS_CLK_SEL)
            clk_sel_r <= wdata_i;
         if (addr_i == fcp_pkg::OFS_POL_CLK)
            pol_clk_r <= wdata_i;
         if (addr_i == fcp_pkg::OFS_SCALE)
            scale_r <= wdata_i;
         if (addr_i == fcp_pkg::OFS_ENABLE)                             // Test bits gated
            enable_r <= (wdata_i & fcp_pkg::EN_WR_MASK) |
                        (test_mode_i ? (wdata_i & fcp_pkg::TEST_MASK) :
                                       (enable_r & fcp_pkg::TEST_MASK));
         if (in_per)
            per_r[sel_ch] <= wdata_i;
         if (in_dty)
            dty_r[sel_ch] <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path with high-byte snapshot of the low byte
   wire [1:0] hi_rd;
   assign hi_rd[0] = rd_i && in_cnt && sel_ch == 2'd0 && join_w[0];
   assign hi_rd[1] = rd_i && in_cnt && sel_ch == 2'd2 && join_w[1];
   wire       lo_pair = sel_ch[1];
   wire       use_snap = in_cnt && sel_ch[0] && snap_vld_r[lo_pair];
   wire [7:0] scale_rd = s_test ? {7'h00, s_tick_r} : scale_r;
   wire [7:0] rd_mux =
      (addr_i == fcp_pkg::OFS_CLK_SEL) ? clk_sel_r :
      (addr_i == fcp_pkg::OFS_POL_CLK) ? pol_clk_r :
      (addr_i == fcp_pkg::OFS_SCALE)   ? scale_rd  :
      (addr_i == fcp_pkg::OFS_ENABLE)  ? enable_r  :
      use_snap ? snap_r[lo_pair] :
      in_cnt ? cnt_r[sel_ch] :
      in_per ? per_r[sel_ch] :
      in_dty ? dty_r[sel_ch] : 8'h00;                                   // Unmapped reads zero

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         rdata_r    <= 8'h00;
         snap_vld_r <= 2'b00;
         snap_r[0]  <= 8'h00;
         snap_r[1]  <= 8'h00;
      end
      else if (ce_i)
      begin
         rdata_r    <= rd_i ? rd_mux : 8'h00;
         snap_vld_r <= hi_rd;                                           // One cycle only
         if (hi_rd[0])
            snap_r[0] <= cnt_r[1];
         if (hi_rd[1])
            snap_r[1] <= cnt_r[3];
      end
   end
   assign rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_wr_cnt0;
      wr_i && ce_i && addr_i == fcp_pkg::OFS_CNT_BASE && !join_w[0];
   endsequence
   a_cnt_write_clr: assert property (@(posedge clk_i) disable iff (srst_i)
      s_wr_cnt0 |=> cnt_r[0] == 8'h00)
      else $error("counter write did not clear");
   a_hi_write_ign: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && join_w[0] && !cnt_wr[0] && !(raw_tick[1] && en[1])) |=>
      cnt_r[0] == $past(cnt_r[0]))
      else $error("joined high byte changed without cause");
   a_test_locked: assert property (@(posedge clk_i) disable iff (srst_i)
      !test_mode_i |=> (enable_r & fcp_pkg::TEST_MASK) == $past(enable_r & fcp_pkg::TEST_MASK))
      else $error("test bits changed outside test mode");
   a_period_load: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && cnt_wr[0]) |=> per_act_r[0] == $past(per_r[0]))
      else $error("period not loaded on clear");
   a_pin_release: assert property (@(posedge clk_i) disable iff (srst_i)
      join_w[0] |-> !pwm_drive_o[0])
      else $error("high-order pin still driven");
   a_disabled_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      (!en[2] && !join_w[1] && !cnt_wr[2]) |=> cnt_r[2] == $past(cnt_r[2]))
      else $error("disabled counter moved");
   a_tick_a_rate: assert property (@(posedge clk_i) disable iff (srst_i)
      (pre_a == 2'd0 && ce_i) |-> tick_a)
      else $error("clock A undivided missing tick");
   a_dty_invert: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && !join_w[1] && en[2] && raw_tick[2] && cnt_r[2] == dty_act_r[2] &&
       cnt_r[2] != per_act_r[2] && !cnt_wr[2]) |=> lvl_r[2] == ~$past(pol[2]))
      else $error("duty match did not invert");
   // A back-to-back high read may renew the flag, so only the cycle after a read is checked
   a_snap_one: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && hi_rd[0]) |=> snap_vld_r[0])
      else $error("snapshot flag wrong");
   // Without a fresh high read the flag must drop after one cycle
   a_snap_drop: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && !hi_rd[0]) |=> !snap_vld_r[0])
      else $error("snapshot flag held too long");

   // Channel 1 running alone, ticking, with no software clear in the way
   sequence s_tick0_free;
      ce_i && !join_w[0] && en[0] && raw_tick[0] && !cnt_wr[0];
   endsequence
   // Clock B at divide-by-2 with the field left alone for one more cycle
   sequence s_b_half;
      (ce_i && tick_b && pre_b == 3'd1) ##1 (pre_b == 3'd1);
   endsequence

   // Period match restarts at zero with the polarity level
   a_per_match_clr: assert property (@(posedge clk_i) disable iff (srst_i)
      s_tick0_free ##0 (cnt_r[0] == per_act_r[0] && !no_clr) |=>
      (cnt_r[0] == 8'h00 && lvl_r[0] == $past(pol[0])))
      else $error("period match did not restart");
   // With the inhibit test bit set, a period match keeps counting
   a_noclr_keep: assert property (@(posedge clk_i) disable iff (srst_i)
      s_tick0_free ##0 (cnt_r[0] == per_act_r[0] && no_clr) |=>
      cnt_r[0] == 8'($past(cnt_r[0]) + 8'h01))
      else $error("inhibited match cleared counter");
   // Plain ticks advance the counter by exactly one
   a_tick_count: assert property (@(posedge clk_i) disable iff (srst_i)
      s_tick0_free ##0 (cnt_r[0] != per_act_r[0]) |=>
      cnt_r[0] == 8'($past(cnt_r[0]) + 8'h01))
      else $error("counter did not advance");
   // Clock B divided by two never ticks twice in a row
   a_tick_b_rate: assert property (@(posedge clk_i) disable iff (srst_i)
      s_b_half |-> !tick_b)
      else $error("clock B ticked too often");
   // Divisor one on undivided clock A: S ticks every second cycle
   a_tick_s_gap: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && !wr_i && tick_s && scale_r == 8'h01 && pre_a == 2'd0) |=> !tick_s)
      else $error("clock S missed its halving");
   // Joined pair carries from the low byte into the high byte
   a_join_carry: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && join_w[1] && en[3] && raw_tick[3] && !per_m16[1] && !cnt_wr[2] &&
       cnt_r[3] == 8'hff) |=> (cnt_r[3] == 8'h00 && cnt_r[2] == 8'($past(cnt_r[2]) + 8'h01)))
      else $error("joined carry lost");
   // Joined low-byte write clears all sixteen bits
   a_low_wr_clr16: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && wr_i && join_w[1] && addr_i == fcp_pkg::OFS_CNT_BASE + 5'h03) |=>
      (cnt_r[2] == 8'h00 && cnt_r[3] == 8'h00))
      else $error("joined counter not cleared");
   // Read data stand for one cycle only and return zero otherwise
   a_rd_idle: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && !rd_i) |=> rdata_o == 8'h00)
      else $error("read data without a read");

endmodule
`default_nettype wire

//--- rtl/fcp_pkg.sv
`default_nettype none
package fcp_pkg;
   localparam int unsigned ADDR_W = 5;
   // Register offsets (byte-wide registers on a plain port)
   localparam logic [4:0] OFS_CLK_SEL  = 5'h00;
   localparam logic [4:0] OFS_POL_CLK  = 5'h01;
   localparam logic [4:0] OFS_SCALE    = 5'h02;
   localparam logic [4:0] OFS_ENABLE   = 5'h03;
   localparam logic [4:0] OFS_CNT_BASE = 5'h04;
   localparam logic [4:0] OFS_PER_BASE = 5'h08;
   localparam logic [4:0] OFS_DTY_BASE = 5'h0c;
   // Field positions in clock_select_ctrl
   localparam int unsigned JOIN2_BIT  = 7;
   localparam int unsigned JOIN1_BIT  = 6;
   localparam int unsigned PRE_A_LSB  = 4;
   localparam int unsigned PRE_B_LSB  = 0;
   // Field positions in polarity_clock_ctrl
   localparam int unsigned PICK_LSB   = 4;
   localparam int unsigned POL_LSB    = 0;
   // Field positions in channel_enable_ctrl
   localparam int unsigned STEST_BIT  = 7;
   localparam int unsigned NOCLR_BIT  = 5;
   localparam int unsigned EN_LSB     = 0;
   // Reset values and write masks
   localparam logic [7:0] RST_CTRL    = 8'h00;
   localparam logic [7:0] RST_PER     = 8'hff;
   localparam logic [7:0] RST_DTY     = 8'hff;
   localparam logic [7:0] EN_WR_MASK  = 8'h0f;
   localparam logic [7:0] TEST_MASK   = 8'ha0;
endpackage
`default_nettype wire

//--- verif/fcp_load_model.sv
`default_nettype none
// Loads on port H; a pull-down holds any released pin low
module fcp_load_model
(
   input  wire logic        clk_i,
   input  wire logic [3:0]  pwm_i,
   input  wire logic [3:0]  drive_i,
   output logic             evt_o,
   output logic [1:0]       pin_o,
   output logic [15:0]      hi_o,
   output logic [15:0]      per_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  lvl;
   logic [3:0]  lvl_r;
   logic [3:0]  rise;
   logic [15:0] hi_c;
   logic [15:0] per_c;
   logic [15:0] hi_l;

   // Pin level seen by the load
   assign lvl = drive_i & pwm_i;
   assign rise = lvl & ~lvl_r;

   // Report period and high time at each rising pin; one busy pin at a time
   always_ff @(posedge clk_i)
   begin
      lvl_r <= lvl;
      evt_o <= |rise;
      if (|rise)
      begin
         pin_o <= rise[0] ? 2'd0 : rise[1] ? 2'd1 : rise[2] ? 2'd2 : 2'd3;
         per_o <= per_c;
         hi_o  <= hi_l;
         per_c <= 16'h1;
         hi_c  <= 16'h1;
      end
      else
      begin
         per_c <= per_c + 16'h1;
         if (|lvl)
            hi_c <= hi_c + 16'h1;
      end
      if (|(lvl_r & ~lvl))
         hi_l <= hi_c;
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i;
   logic        srst_i;
   logic        ce_i;
   logic        test_mode_i;
   logic        wr_i;
   logic        rd_i;
   logic        rd_d;
   logic        evt;
   logic [4:0]  addr_i;
   logic [7:0]  wdata_i;
   logic [7:0]  rdata_o;
   logic [3:0]  pwm_o;
   logic [3:0]  pwm_drive_o;
   logic [1:0]  pin;
   logic [15:0] hi;
   logic [15:0] per;
   logic [7:0]  rq[$];
   logic [33:0] eq[$];
   int          error_cnt;
   int          checks;
   int          seed;
   int          p;
   int          d;
   int          k;
   int          c;
   int          s;
   int          t;
   int          w;

   fcp_pwm_timer dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
      .test_mode_i(test_mode_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .pwm_o(pwm_o), .pwm_drive_o(pwm_drive_o));
   fcp_load_model load_u (.clk_i(clk_i), .pwm_i(pwm_o), .drive_i(pwm_drive_o),
      .evt_o(evt), .pin_o(pin), .hi_o(hi), .per_o(per));

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic end_of_test();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cmp(input logic [33:0] g, input logic [33:0] e);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
      cmp(34'(g), 34'(e));
   endtask
   task automatic cmp_wave(input logic [33:0] g, input logic [33:0] e);
      cmp(g, e);
   endtask
   task automatic cmp_drv(input logic [3:0] g, input logic [3:0] e);
      cmp(34'(g), 34'(e));
   endtask

   // Results are judged against the oldest note as they appear
   always @(posedge clk_i)
   begin
      if (rd_d && rq.size() > 0)
         cmp_rd(rdata_o, rq.pop_front());
      if (evt && eq.size() > 0)
         cmp_wave({pin, hi, per}, eq.pop_front());
      rd_d <= rd_i;
   end

   // Bus cycles; strobes stay up so back-to-back cycles need no gap
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      rq.push_back(e);
      @(posedge clk_i);
   endtask
   task automatic idle(input int n);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask

   // Skip the partial first periods, then expect two whole ones
   task automatic wave(input logic [1:0] pn, input int h, input int tp);
      idle(3 * tp + 8);
      repeat (2) eq.push_back({pn, 16'(h), 16'(tp)});
      for (w = 0; w < 4 * tp + 50 && eq.size() > 0; w++)
         @(posedge clk_i);
      if (eq.size() > 0)
      begin
         error_cnt++;
         end_of_test();
      end
   endtask

   initial
   begin
      seed = 61329;
      error_cnt = 0;
      checks = 0;
      rd_d = 1'b0;
      srst_i = 1'b1;
      ce_i = 1'b1;
      test_mode_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 5'h00;
      wdata_i = 8'h00;
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      // Reset contents, then an unmapped place
      for (k = 0; k < 16; k++)
         rd(5'(k), (k >= 8) ? 8'hff : 8'h00);
      rd(5'h15, 8'h00);
      // Plain registers read back what was written
      for (k = 0; k < 16; k++)
         if (k < 3 || k >= 8)
         begin
            d = $random(seed) & ((k == 0) ? 32'hf7 : 32'hff);
            wr(5'(k), 8'(d));
            rd(5'(k), 8'(d));
         end
      // Test bits ignore writes outside test mode
      wr(fcp_pkg::OFS_ENABLE, 8'hf0);
      rd(fcp_pkg::OFS_ENABLE, 8'h00);
      test_mode_i <= 1'b1;
      wr(fcp_pkg::OFS_ENABLE, 8'hf0);
      rd(fcp_pkg::OFS_ENABLE, fcp_pkg::TEST_MASK);
      wr(fcp_pkg::OFS_ENABLE, 8'h00);
      test_mode_i <= 1'b0;
      // Chan 1 on clock A, chan 3 inverted on clock B, chan 2 on clock S
      for (k = 0; k < 14; k++)
      begin
         c = (k < 4) ? 0 : (k < 12) ? 2 : 1;
         s = (k < 4) ? k : (k < 12) ? k - 4 : 1;
         t = (c == 1) ? 4 * (2 * k - 23) : 1 << s;
         p = 8 + ($random(seed) & 15);
         d = 1 + ($random(seed) & 3);
         wr(fcp_pkg::OFS_ENABLE, 8'h00);
         wr(fcp_pkg::OFS_CLK_SEL, 8'((c == 2) ? s : s << 4));
         wr(fcp_pkg::OFS_POL_CLK, (c == 2) ? 8'h04 : (c == 1) ? 8'h20 : 8'h00);
         wr(fcp_pkg::OFS_SCALE, 8'(2 * k - 23));
         wr(5'(fcp_pkg::OFS_PER_BASE + c), 8'(p));
         wr(5'(fcp_pkg::OFS_DTY_BASE + c), 8'(d));
         wr(5'(fcp_pkg::OFS_CNT_BASE + c), 8'h5a);
         wr(fcp_pkg::OFS_ENABLE, 8'(1 << c));
         idle(1);
         cmp_drv(pwm_drive_o, 4'(1 << c));
         wave(2'(c), ((c == 2) ? d + 1 : p - d) * t, (p + 1) * t);
      end
      // Channels 3 and 4 joined; chan 3 picks clock S, which must not matter
      wr(fcp_pkg::OFS_ENABLE, 8'h00);
      wr(fcp_pkg::OFS_CLK_SEL, 8'h80);
      wr(fcp_pkg::OFS_POL_CLK, 8'h40);
      wr(5'h0a, 8'h01);
      wr(5'h0b, 8'h10);
      wr(5'h0e, 8'h00);
      wr(5'h0f, 8'h20);
      wr(5'h07, 8'h00);
      wr(fcp_pkg::OFS_ENABLE, 8'h0c);
      idle(1);
      cmp_drv(pwm_drive_o, 4'h8);
      wave(2'd3, 16'h110 - 16'h20, 16'h111);
      // Low-byte write clears the frozen pair; high then low read back zero
      wr(fcp_pkg::OFS_ENABLE, 8'h00);
      wr(5'h07, 8'h33);
      rd(5'h06, 8'h00);
      rd(5'h07, 8'h00);
      idle(4);
      end_of_test();
   end
endmodule
`default_nettype wire
